// [data_move_decoder.sv]
// Sequencer for data-move, port, bit and machine-control operations.
`timescale 1ns/100ps
`include "data_move_regs.svh"
module data_move_decoder #(
   parameter logic [15:0] STACK_TOP = `STACK_TOP_RESET
) (
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               op_valid,
   input  wire data_move_pkg::op_e op_code,
   input  wire logic [4:0]         op_reg,
   input  wire logic [5:0]         op_disp,
   input  wire logic [15:0]        op_addr,
   input  wire logic [2:0]         op_bit,
   input  wire logic [7:0]         src_data,
   input  wire logic               dbg_en,
   input  wire logic               z_load,
   input  wire logic [15:0]        z_load_val,
   input  wire logic [7:0]         dm_rdata,
   input  wire logic [15:0]        cm_rdata,
   output logic                    op_ready,
   output logic                    op_done,
   output logic [15:0]             dm_addr,
   output logic [7:0]              dm_wdata,
   output logic [7:0]              dm_mask,
   output logic                    dm_we,
   output logic                    dm_re,
   output logic [14:0]             cm_addr,
   output logic                    cm_re,
   output logic                    rf_we,
   output logic [4:0]              rf_addr,
   output logic [7:0]              rf_wdata,
   output logic [15:0]             z_ptr,
   output logic [15:0]             sp,
   output logic                    skip,
   output logic                    wdt_restart,
   output logic                    sleep_req,
   output logic                    brk,
   output logic                    io_fault
);
   import data_move_pkg::*;

   seq_state_e  state_reg;
   op_e         cur_op_reg;
   logic [4:0]  cur_dst_reg;
   logic [2:0]  cur_bit_reg;
   logic        cur_legal_reg;
   logic        cur_zlsb_reg;
   logic        in_pend_reg;
   logic [4:0]  in_dst_reg;
   logic [7:0]  fetch_hold_reg;
   logic        take;
   logic        is_fetch;
   io_map_if    map_bus ();

   io_space_map u_map (
      .m (map_bus.map)
   );

   // =====================================================================
   // Decode helpers
   // An operation is taken on any enabled edge where it is offered while ready.
   assign take     = op_valid && op_ready;
   assign is_fetch = (op_code == op_code_fetch_low) || (op_code == op_code_fetch) ||
                     (op_code == op_code_fetch_inc);

   // Address space selection feeds the mapper.
   always_comb begin
      map_bus.addr = op_addr;
      case (op_code)
         op_port_read, op_port_write: map_bus.kind = map_port;
         op_io_bit_set, op_io_bit_clear,
         op_skip_if_io_bit_high, op_skip_if_io_bit_low: map_bus.kind = map_bit;
         default: map_bus.kind = map_data;
      endcase
   end

   // =====================================================================
   // Sequencer
   // Ready drops while a multi-cycle operation runs, so the count is exact.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= seq_idle;
         op_ready      <= 1'b1;
         op_done       <= 1'b0;
         cur_op_reg    <= op_nop;
         cur_dst_reg   <= 5'h00;
         cur_bit_reg   <= 3'h0;
         cur_legal_reg <= 1'b0;
         cur_zlsb_reg  <= 1'b0;
      end else if (ce) begin
         op_done <= 1'b0;
         case (state_reg)
            seq_idle: begin
               if (take) begin
                  cur_op_reg    <= op_code;
                  cur_dst_reg   <= (op_code == op_code_fetch_low) ? 5'h00 : op_reg;
                  cur_bit_reg   <= op_bit;
                  cur_legal_reg <= map_bus.legal;
                  cur_zlsb_reg  <= z_ptr[0];
                  case (op_code)
                     op_nop, op_sleep, op_watchdog_restart, op_break,
                     op_port_read, op_port_write: op_done <= 1'b1;
                     default: begin
                        op_ready  <= 1'b0;
                        state_reg <= seq_step1;
                     end
                  endcase
               end
            end
            seq_step1: begin
               if (cur_op_reg inside {op_code_fetch_low, op_code_fetch, op_code_fetch_inc}) begin
                  state_reg <= seq_step2;
               end else begin
                  state_reg <= seq_idle;
                  op_ready  <= 1'b1;
                  op_done   <= 1'b1;
               end
            end
            seq_step2: begin
               state_reg <= seq_idle;
               op_ready  <= 1'b1;
               op_done   <= 1'b1;
            end
            default: begin
               state_reg <= seq_idle;
               op_ready  <= 1'b1;
            end
         endcase
      end
   end

   // =====================================================================
   // Data and code memory strobes
   // Addresses are captured at the take edge; memories answer within the
   // strobe cycle, which is what keeps loads at two cycles.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dm_addr  <= 16'h0000;
         dm_wdata <= 8'h00;
         dm_mask  <= `FULL_MASK;
         dm_we    <= 1'b0;
         dm_re    <= 1'b0;
         cm_addr  <= 15'h0000;
         cm_re    <= 1'b0;
         io_fault <= 1'b0;
      end else if (ce) begin
         dm_we    <= 1'b0;
         dm_re    <= 1'b0;
         cm_re    <= 1'b0;
         io_fault <= 1'b0;
         if (take) begin
            dm_wdata <= src_data;
            dm_mask  <= `FULL_MASK;
            dm_addr  <= map_bus.ds_addr;
            case (op_code)
               op_indirect_write_inc: begin
                  dm_addr <= z_ptr;
                  dm_we   <= 1'b1;
               end
               op_indirect_write_dec: begin
                  dm_addr <= z_ptr - `ONE_WORD;
                  dm_we   <= 1'b1;
               end
               op_offset_write: begin
                  dm_addr <= z_ptr + {10'h000, op_disp};
                  dm_we   <= 1'b1;
               end
               op_absolute_write, op_port_write: begin
                  dm_we    <= map_bus.legal;
                  io_fault <= !map_bus.legal;
               end
               op_absolute_load, op_port_read, op_skip_if_io_bit_high,
               op_skip_if_io_bit_low: begin
                  dm_re    <= map_bus.legal;
                  io_fault <= !map_bus.legal;
               end
               op_io_bit_set, op_io_bit_clear: begin
                  dm_mask  <= 8'h01 << op_bit;
                  dm_wdata <= (op_code == op_io_bit_set) ? (8'h01 << op_bit) : 8'h00;
                  dm_we    <= map_bus.legal;
                  io_fault <= !map_bus.legal;
               end
               op_push: begin
                  dm_addr <= sp;
                  dm_we   <= 1'b1;
               end
               op_pop: begin
                  dm_addr <= sp + `ONE_WORD;
                  dm_re   <= 1'b1;
               end
               op_code_fetch_low, op_code_fetch, op_code_fetch_inc: begin
                  cm_addr <= z_ptr[15:1];
                  cm_re   <= 1'b1;
               end
               default: dm_addr <= dm_addr;
            endcase
         end
      end
   end

   // =====================================================================
   // Pointer and stack pointer
   // No status flag is touched anywhere in this block.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         z_ptr <= 16'h0000;
         sp    <= STACK_TOP;
      end else if (ce) begin
         if (z_load) begin
            z_ptr <= z_load_val;
         end else if (take && op_code == op_indirect_write_dec) begin
            z_ptr <= z_ptr - `ONE_WORD;
         end else if (state_reg == seq_step1 && cur_op_reg == op_indirect_write_inc) begin
            z_ptr <= z_ptr + `ONE_WORD;
         end else if (state_reg == seq_step2 && cur_op_reg == op_code_fetch_inc) begin
            z_ptr <= z_ptr + `ONE_WORD;
         end
         if (take && op_code == op_push) begin
            sp <= sp - `ONE_WORD;
         end else if (take && op_code == op_pop) begin
            sp <= sp + `ONE_WORD;
         end
      end
   end

   // =====================================================================
   // Register file write-back and skip result
   // A port read completes in the cycle after the take while ready stays
   // high; no other load writes back in that cycle, so writes never clash.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rf_we          <= 1'b0;
         rf_addr        <= 5'h00;
         rf_wdata       <= 8'h00;
         in_pend_reg    <= 1'b0;
         in_dst_reg     <= 5'h00;
         fetch_hold_reg <= 8'h00;
         skip           <= 1'b0;
      end else if (ce) begin
         rf_we       <= 1'b0;
         skip        <= 1'b0;
         in_pend_reg <= take && op_code == op_port_read && map_bus.legal;
         in_dst_reg  <= op_reg;
         if (in_pend_reg) begin
            rf_we    <= 1'b1;
            rf_addr  <= in_dst_reg;
            rf_wdata <= dm_rdata;
         end
         if (state_reg == seq_step1) begin
            case (cur_op_reg)
               op_pop, op_absolute_load: begin
                  rf_we    <= 1'b1;
                  rf_addr  <= cur_dst_reg;
                  rf_wdata <= dm_rdata;
               end
               op_skip_if_io_bit_high: skip <= cur_legal_reg && dm_rdata[cur_bit_reg];
               op_skip_if_io_bit_low:  skip <= cur_legal_reg && !dm_rdata[cur_bit_reg];
               default: fetch_hold_reg <= cur_zlsb_reg ? cm_rdata[15:8] : cm_rdata[7:0];
            endcase
         end
         if (state_reg == seq_step2) begin
            rf_we    <= 1'b1;
            rf_addr  <= cur_dst_reg;
            rf_wdata <= fetch_hold_reg;
         end
      end
   end

   // =====================================================================
   // Machine control pulses
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_restart <= 1'b0;
         sleep_req   <= 1'b0;
         brk         <= 1'b0;
      end else if (ce) begin
         wdt_restart <= take && op_code == op_watchdog_restart;
         sleep_req   <= take && op_code == op_sleep;
         brk         <= take && op_code == op_break && dbg_en;
      end
   end

   // =====================================================================
   // Assertions
   default clocking cb @(posedge mclk iff ce); endclocking
   default disable iff (!rst_n);

   sequence s_store_then_done;
      dm_we && !op_ready ##1 op_ready && op_done;
   endsequence

   a_post_inc_store: assert property (
      take && op_code == op_indirect_write_inc |=> dm_addr == $past(z_ptr) and s_store_then_done
      ##0 z_ptr == dm_addr + `ONE_WORD) else $error("post-increment store wrong");
   a_pre_dec_store: assert property (
      take && op_code == op_indirect_write_dec && !z_load
      |=> z_ptr == dm_addr && dm_addr == $past(z_ptr) - `ONE_WORD and s_store_then_done)
      else $error("pre-decrement store wrong");
   a_offset_store: assert property (
      take && op_code == op_offset_write && !z_load
      |=> dm_addr == $past(z_ptr) + {10'h000, $past(op_disp)} && z_ptr == $past(z_ptr)
      and s_store_then_done) else $error("displaced store wrong");
   a_absolute_store: assert property (
      take && op_code == op_absolute_write |=> dm_addr == $past(op_addr)
      && dm_wdata == $past(src_data) and s_store_then_done) else $error("direct store wrong");
   a_fetch_three: assert property (
      take && is_fetch |=> cm_re && !op_ready ##1 !op_ready ##1 op_ready && op_done && rf_we)
      else $error("code fetch not three cycles");
   a_fetch_low_dest: assert property (
      take && op_code == op_code_fetch_low |-> ##3 rf_addr == 5'h00)
      else $error("bare code fetch not into low product register");
   a_push_stack: assert property (
      take && op_code == op_push |=> dm_addr == $past(sp) && sp == $past(sp) - `ONE_WORD
      and s_store_then_done) else $error("push wrong");
   a_pop_stack: assert property (
      take && op_code == op_pop |=> dm_re && dm_addr == sp
      ##1 rf_we && rf_wdata == $past(dm_rdata) && op_done) else $error("pop wrong");
   a_watchdog_pulse: assert property (
      take && op_code == op_watchdog_restart |=> wdt_restart && op_ready && op_done)
      else $error("watchdog restart not one cycle");
   a_sleep_pulse: assert property (
      take && op_code == op_sleep |=> sleep_req && op_ready && op_done)
      else $error("sleep not one cycle");
   a_break_gated: assert property (
      brk |-> $past(dbg_en) && $past(op_code) == op_break) else $error("break without debug");
   a_bit_window: assert property (
      take && map_bus.kind == map_bit && op_addr > `IO_BIT_LAST
      |=> io_fault && !dm_we && !dm_re ##1 !skip) else $error("bit op outside window");
   a_bit_only: assert property (
      take && op_code inside {op_io_bit_set, op_io_bit_clear} && op_addr <= `IO_BIT_LAST
      |=> dm_we && dm_mask == (8'h01 << $past(op_bit))) else $error("bit op touches other bits");
   a_port_offset: assert property (
      take && op_code == op_port_write && op_addr <= `IO_PORT_LAST
      |=> dm_we && dm_addr == $past(op_addr) + `IO_DS_OFFSET) else $error("port offset wrong");
   a_port_window: assert property (
      take && map_bus.kind == map_port && op_addr > `IO_PORT_LAST
      |=> io_fault && !dm_we && !dm_re) else $error("port op outside window");
   a_extended_reach: assert property (
      take && op_code == op_absolute_write && op_addr >= `XIO_FIRST && op_addr <= `XIO_LAST
      |=> dm_we && !io_fault) else $error("extended window not reachable");

endmodule : data_move_decoder

// [data_move_pkg.sv]
// Types shared by the data-move decoder and its address mapper.
package data_move_pkg;

   // Decoded operation presented to the decoder.
   typedef enum logic [4:0] {
      op_nop                  = 5'h00,
      op_indirect_write_inc   = 5'h01,
      op_indirect_write_dec   = 5'h02,
      op_offset_write         = 5'h03,
      op_absolute_write       = 5'h04,
      op_code_fetch_low       = 5'h05,
      op_code_fetch           = 5'h06,
      op_code_fetch_inc       = 5'h07,
      op_push                 = 5'h08,
      op_pop                  = 5'h09,
      op_absolute_load        = 5'h0a,
      op_port_read            = 5'h0b,
      op_port_write           = 5'h0c,
      op_io_bit_set           = 5'h0d,
      op_io_bit_clear         = 5'h0e,
      op_skip_if_io_bit_high  = 5'h0f,
      op_skip_if_io_bit_low   = 5'h10,
      op_sleep                = 5'h11,
      op_watchdog_restart     = 5'h12,
      op_break                = 5'h13
   } op_e;

   // Sequencer states, Gray coded along idle, step one, step two.
   typedef enum logic [1:0] {
      seq_idle  = 2'b00,
      seq_step1 = 2'b01,
      seq_step2 = 2'b11
   } seq_state_e;

   // Which address space an access uses.
   typedef enum logic [1:0] {
      map_data = 2'b00,
      map_port = 2'b01,
      map_bit  = 2'b10
   } map_kind_e;

endpackage : data_move_pkg

// [data_move_regs.svh]
// Address-window limits, offsets, mask and reset values for the data-move decoder.
`ifndef DATA_MOVE_REGS_SVH
`define DATA_MOVE_REGS_SVH

// =====================================================================
// I/O space windows
`define IO_BIT_LAST      16'h001f
`define IO_PORT_LAST     16'h003f
`define IO_DS_OFFSET     16'h0020
`define XIO_FIRST        16'h0060
`define XIO_LAST         16'h00ff

// =====================================================================
// Data and reset values
`define FULL_MASK        8'hff
`define STACK_TOP_RESET  16'h00ff
`define ONE_WORD         16'h0001

`endif

// [io_map_if.sv]
// Carrier between the decoder and its I/O address mapper.
`timescale 1ns/100ps
interface io_map_if;
   import data_move_pkg::*;
   map_kind_e   kind;
   logic [15:0] addr;
   logic [15:0] ds_addr;
   logic        legal;

   modport user (output kind, output addr, input ds_addr, input legal);
   modport map  (input kind, input addr, output ds_addr, output legal);
endinterface : io_map_if

// [io_space_map.sv]
// Maps port and bit-access I/O numbers onto data-space addresses.
`timescale 1ns/100ps
`include "data_move_regs.svh"
module io_space_map (
   io_map_if.map m
);
   import data_move_pkg::*;

   // =====================================================================
   // Window check and offset
   // Port and bit numbers sit 0x20 below their data-space image; data
   // accesses pass through so the extended window stays reachable.
   always_comb begin
      m.ds_addr = m.addr;
      m.legal   = 1'b1;
      case (m.kind)
         map_port: begin
            m.legal   = (m.addr <= `IO_PORT_LAST);
            m.ds_addr = m.addr + `IO_DS_OFFSET;
         end
         map_bit: begin
            m.legal   = (m.addr <= `IO_BIT_LAST);
            m.ds_addr = m.addr + `IO_DS_OFFSET;
         end
         default: begin
            m.legal   = 1'b1;
            m.ds_addr = m.addr;
         end
      endcase
   end

endmodule : io_space_map

// [tb_data_move_and_io_space_decode.sv]
// Self-checking bench for the data-move decoder.
`timescale 1ns/100ps
module tb_data_move_and_io_space_decode;
   import data_move_pkg::*;
   localparam logic [15:0] SP0 = 16'h0180;
   // =================================================================
   // Stimulus and observed signals
   logic        mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, op_valid = 1'b0;
   logic        dbg_en = 1'b0, z_load = 1'b0;
   op_e         op_code = op_nop;
   logic [4:0]  op_reg = 5'h00;
   logic [5:0]  op_disp = 6'h00;
   logic [2:0]  op_bit = 3'h0;
   logic [15:0] op_addr = 16'h0000, z_load_val = 16'h0000, cm_rdata = 16'h0000;
   logic [7:0]  src_data = 8'h00, dm_rdata = 8'h00;
   logic        op_ready, op_done, dm_we, dm_re, cm_re, rf_we, skip;
   logic        wdt_restart, sleep_req, brk, io_fault;
   logic [15:0] dm_addr, z_ptr, sp;
   logic [7:0]  dm_wdata, dm_mask, rf_wdata;
   logic [14:0] cm_addr;
   logic [4:0]  rf_addr;
   int          fails = 0, checks_done = 0;
   logic [31:0] seed = 32'h4018;
   logic [15:0] z = 16'h0000, s = SP0;
   logic [15:0] edges [7] = '{16'h0000, 16'h001f, 16'h0020, 16'h003f, 16'h0040,
                             16'h0060, 16'h00ff};

   data_move_decoder #(.STACK_TOP(SP0)) i_dut (.mclk, .rst_n, .ce, .op_valid, .op_code,
      .op_reg, .op_disp, .op_addr, .op_bit, .src_data, .dbg_en, .z_load, .z_load_val,
      .dm_rdata, .cm_rdata, .op_ready, .op_done, .dm_addr, .dm_wdata, .dm_mask, .dm_we,
      .dm_re, .cm_addr, .cm_re, .rf_we, .rf_addr, .rf_wdata, .z_ptr, .sp, .skip,
      .wdt_restart, .sleep_req, .brk, .io_fault);

   // Free-running system clock.
   always #12.5 mclk = ~mclk;

   // =================================================================
   // Helpers
   function automatic void step();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction : step

   // Write lanes expected for a single-bit access to bit b.
   function automatic logic [7:0] lane_of(input logic [2:0] b);
      return 8'h01 << b;
   endfunction : lane_of

   // Byte of a code word that a pointer with the given low bit selects.
   function automatic logic [7:0] byte_of(input logic [15:0] wd, input logic lsb);
      return lsb ? wd[15:8] : wd[7:0];
   endfunction : byte_of

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   // Idle values hold while reset is asserted and just after it.
   task automatic rchk;
      chk("op_ready", 16'h0001, op_ready);
      chk("z_ptr", 16'h0000, z_ptr);
      chk("sp", SP0, sp);
      chk("dm_mask", 16'h00ff, dm_mask);
      chk("pulses", 16'h0000, {dm_we, dm_re, cm_re, rf_we, skip, op_done, io_fault});
   endtask : rchk

   // Loads the pointer in one idle edge.
   task automatic zld(input logic [15:0] v);
      z_load = 1'b1;
      z_load_val = v;
      @(negedge mclk);
      z_load = 1'b0;
      z = v;
   endtask : zld

   // Issues one operation and checks every cycle until it has settled.
   task automatic run(input op_e c, input logic [15:0] a);
      logic [6:0]  stb;
      logic [15:0] ea, ez;
      logic [7:0]  m, w;
      logic [4:0]  ra;
      logic        rfw, sk, io, port, flt;
      int          n, rc;
      step();
      op_reg = seed[4:0];
      op_disp = seed[10:5];
      op_bit = seed[13:11];
      src_data = seed[21:14];
      dbg_en = seed[22];
      step();
      dm_rdata = seed[7:0];
      cm_rdata = seed[23:8];
      op_code = c;
      op_addr = a;
      op_valid = 1'b1;
      n = 2;
      rc = 2;
      stb = 7'h00;
      ea = a;
      ez = z;
      m = 8'hff;
      w = src_data;
      rfw = 1'b0;
      sk = 1'b0;
      ra = (c == op_code_fetch_low) ? 5'h00 : op_reg;
      io = c >= op_port_read && c <= op_skip_if_io_bit_low;
      port = io && c <= op_port_write;
      flt = io && a > (port ? 16'h003f : 16'h001f);
      // Expected strobes, addresses and pointer moves per operation.
      case (c)
         op_indirect_write_inc: begin stb = 7'h40; ea = z; ez = z + 16'h0001; end
         op_indirect_write_dec: begin z = z - 16'h0001; stb = 7'h40; ea = z; ez = z; end
         op_offset_write: begin stb = 7'h40; ea = z + {10'h000, op_disp}; end
         op_absolute_write, op_port_write: stb = 7'h40;
         op_push: begin stb = 7'h40; ea = s; s = s - 16'h0001; end
         op_pop: begin s = s + 16'h0001; stb = 7'h20; ea = s; rfw = 1'b1; w = dm_rdata; end
         op_absolute_load, op_port_read: begin stb = 7'h20; rfw = 1'b1; w = dm_rdata; end
         op_code_fetch_low, op_code_fetch, op_code_fetch_inc: begin
            n = 3;
            rc = 3;
            stb = 7'h10;
            rfw = 1'b1;
            w = byte_of(cm_rdata, z[0]);
            if (c == op_code_fetch_inc) ez = z + 16'h0001;
         end
         op_io_bit_set, op_io_bit_clear: begin
            stb = 7'h40;
            m = lane_of(op_bit);
            w = (c == op_io_bit_set) ? m : 8'h00;
         end
         op_skip_if_io_bit_high, op_skip_if_io_bit_low: begin
            stb = 7'h20;
            sk = dm_rdata[op_bit] == (c == op_skip_if_io_bit_high);
         end
         op_watchdog_restart: begin n = 1; stb = 7'h08; end
         op_sleep: begin n = 1; stb = 7'h04; end
         op_break: begin n = 1; stb = {5'h00, dbg_en, 1'b0}; end
         default: n = 1;
      endcase
      if (io) ea = a + 16'h0020;
      if (port) n = 1;
      // A number outside its window makes no access at all.
      if (flt) begin stb = 7'h01; rfw = 1'b0; sk = 1'b0; end
      @(posedge mclk);
      @(negedge mclk);
      op_valid = 1'b0;
      for (int k = 1; k <= ((n > 2) ? n : 2); k++) begin
         if (k > 1) @(negedge mclk);
         chk("strobes", (k == 1) ? stb : 7'h00,
             {dm_we, dm_re, cm_re, wdt_restart, sleep_req, brk, io_fault});
         chk("op_done", k == n, op_done);
         chk("op_ready", k >= n, op_ready);
         chk("rf_we", rfw && k == rc, rf_we);
         chk("skip", sk && k == n, skip);
         chk("z_ptr", (k >= n) ? ez : z, z_ptr);
         chk("sp", s, sp);
         if (k == 1 && (stb[6] || stb[5])) chk("dm_addr", ea, dm_addr);
         if (k == 1 && stb[6]) chk("dm_mask", m, dm_mask);
         if (k == 1 && stb[6]) chk("dm_wdata", w, dm_wdata);
         if (k == 1 && stb[4]) chk("cm_addr", {1'b0, z[15:1]}, cm_addr);
         if (rfw && k == rc) chk("rf_addr", ra, rf_addr);
         if (rfw && k == rc) chk("rf_wdata", w, rf_wdata);
      end
      z = ez;
   endtask : run

   // =================================================================
   // Main sequence: edges of each window, random traffic, stalls.
   initial begin
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      rchk();
      zld(16'hffff);
      run(op_indirect_write_inc, 16'h0000);
      run(op_indirect_write_dec, 16'h0000);
      for (int c = 0; c < 20; c++) begin
         foreach (edges[i]) begin
            step();
            zld(seed[15:0]);
            run(op_e'(c), edges[i]);
         end
      end
      repeat (300) begin
         step();
         if (seed[0]) zld(seed[31:16]);
         run(op_e'(seed[4:0] % 20), {8'h00, seed[15:8]});
      end
      // An offer made while busy must be dropped, not queued.
      op_code = op_indirect_write_inc;
      op_valid = 1'b1;
      @(negedge mclk);
      op_code = op_watchdog_restart;
      @(negedge mclk);
      op_valid = 1'b0;
      chk("wdt_restart", 16'h0000, wdt_restart);
      @(negedge mclk);
      chk("wdt_restart", 16'h0000, wdt_restart);
      z = z + 16'h0001;
      // Clock enable low freezes a push in mid-flight.
      op_code = op_push;
      op_valid = 1'b1;
      @(negedge mclk);
      op_valid = 1'b0;
      ce = 1'b0;
      repeat (3) @(negedge mclk);
      chk("frozen", 16'h0002, {dm_we, op_done});
      ce = 1'b1;
      @(negedge mclk);
      chk("op_done", 16'h0001, op_done);
      s = s - 16'h0001;
      chk("sp", s, sp);
      rst_n = 1'b0;
      @(negedge mclk);
      rchk();
      rst_n = 1'b1;
      z = 16'h0000;
      s = SP0;
      @(negedge mclk);
      rchk();
      run(op_pop, 16'h0000);
      end_sim();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #250000;
      fails++;
      end_sim();
   end
endmodule : tb_data_move_and_io_space_decode
